// >>> verilog/ssrw_map.vh
/*
  ssrw_map.vh: timing constants and counter widths for the supply
  supervisor with reset and watchdog.
  Assumes a 40 MHz system clock; tick and push times are turned into cycle counts here.
*/
`ifndef SSRW_MAP_VH
`define SSRW_MAP_VH

// system clock rate in hertz
`define SSRW_CLK_HZ        40000000
// internal tick period in microseconds; all long timeouts count ticks
`define SSRW_TICK_US       1000
`define SSRW_TICK_CYC      ((`SSRW_CLK_HZ / 1000000) * `SSRW_TICK_US)
`define SSRW_TICK_W        16

// release hold time in ms, fixed variant and delay-adjustable variant
`define SSRW_HOLD_MS       200
`define SSRW_HOLD_ADJ_MS   250
// manual reset least low time in ns, rounded up to cycles
`define SSRW_PUSH_NS       1000
`define SSRW_PUSH_CYC      ((`SSRW_PUSH_NS * (`SSRW_CLK_HZ / 1000000) + 999) / 1000)
`define SSRW_PUSH_W        8
// kick window normal 1600 ms, startup 51000 ms, counted in ms ticks
`define SSRW_KICK_MS       1600
`define SSRW_START_MS      51000
`define SSRW_MS_W          17

// zero, one and all-ones constants at the widths they meet
`define SSRW_TICK_ZERO     16'h0000
`define SSRW_MS_ZERO       17'h00000
`define SSRW_PUSH_ZERO     8'h00
`define SSRW_SYNC_ZERO     2'h0
`define SSRW_SYNC_ONES     2'h3
`define SSRW_MS_ONE        17'h00001
`define SSRW_PUSH_ONE      8'h01
`define SSRW_TICK_ONE      16'h0001

`endif

// >>> verilog/ssrw_sync2.v
/*
  ssrw_sync2.v: two flip-flop synchroniser for one asynchronous level.
  Assumes the input is a pin or comparator flag outside sys_clk's domain.
*/
`timescale 1ns/1ps
`include "ssrw_map.vh"

module ssrw_sync2 #(
  parameter RESET_VAL = 1'b0
) (
  // clock and reset
  input  wire sys_clk,
  input  wire srst,
  // asynchronous level in, synchronised level out
  input  wire asyncIn,
  output wire syncOut
);

  reg [1:0] stage;

  // first stage feeds only the second stage
  always @(posedge sys_clk) begin
    if (srst) begin
      stage <= RESET_VAL ? `SSRW_SYNC_ONES : `SSRW_SYNC_ZERO;
    end else begin
      stage <= {stage[0], asyncIn};
    end
  end

  assign syncOut = stage[1];

endmodule // ssrw_sync2

// >>> verilog/ssrw_supervisor.v
/*
  ssrw_supervisor.v: reset supervisor core. Combines supply and adjustable
  input undervoltage flags, power-on, a debounced shared manual reset pin
  and a kick-fed watchdog into one reset state with complementary outputs.
  Assumes comparator flags and pins are asynchronous; srst models power-up
  (supply at about one volt) and is the only reset.
*/
`timescale 1ns/1ps
`include "ssrw_map.vh"

// Notes on behaviour
// R01: reset asserts while the supply or adjustable input is below trip.
// R02: after undervoltage, reset holds until all levels stay good for the hold time.
// R03: at power-up reset asserts with the high output high and low output low.
// R04: delay-adjustable variants use a 250 ms hold that may be raised.
// R05: the manual reset input is active low and debounced before use.
// R06: a manual low of at least one microsecond asserts reset.
// R07: after manual release both outputs stay asserted for the hold time; the code counts it from assertion, as its pin drive hides the button.
// R08: a watchdog expiry without a kick within 1.6 s asserts reset.
// R09: the normal watchdog counter clears on any reset and on every kick.
// R10: a 51 s startup window after power-on never trips on missing kicks.
// R11: on the dual variant release needs both thresholds satisfied.
// R12: the low reset output and the manual input share one open-drain pin.
// R13: the host should kick at least once per second for margin.
// R14: rising and falling kick edges both count as a kick.
// R15: normal timeout lies in 1.0 to 2.0 s, startup in 32 to 64 s.
// R16: timeouts use a free-running tick; inputs are synchronised first.
// R17: the high and low reset outputs are exact complements of one state.
module ssrw_supervisor #(
  parameter ADJ_DELAY     = 0,     // 1 selects the delay-adjustable hold
  parameter DUAL_MON      = 1,     // 1 checks the adjustable input too
  parameter HAS_WATCHDOG  = 1,     // 1 enables the kick watchdog
  parameter HOLD_MS       = (ADJ_DELAY != 0) ? `SSRW_HOLD_ADJ_MS
                                             : `SSRW_HOLD_MS,
  parameter KICK_MS       = `SSRW_KICK_MS,
  parameter START_MS      = `SSRW_START_MS,
  parameter TICK_CYC      = `SSRW_TICK_CYC
) (
  // clock and power-up reset
  input  wire sys_clk,
  input  wire srst,
  // comparator flags, high when the level is above its trip point
  input  wire supplyOk,
  input  wire senseOk,
  // watchdog kick from the host
  input  wire kickInput,
  // shared open-drain pin: level in, drive out, drive enable
  input  wire resetPinIn,
  output reg  resetPinOut,
  output reg  resetPinOe,
  // complementary reset outputs
  output reg  resetHigh,
  output reg  resetOutLow
);

  // states of the reset sequencer
  localparam ST_HOLD = 1'b0;  // reset asserted, counting release hold
  localparam ST_RUN  = 1'b1;  // reset released

  wire supplySync;
  wire senseSync;
  wire kickSync;
  wire pinSync;

  reg                      state;
  reg                      next_state;
  reg  [`SSRW_TICK_W-1:0]  tickCnt;
  reg                      tick;
  reg  [`SSRW_MS_W-1:0]    holdCnt;
  reg  [`SSRW_MS_W-1:0]    kickCnt;
  reg  [`SSRW_MS_W-1:0]    startCnt;
  reg                      startDone;
  reg  [`SSRW_PUSH_W-1:0]  pushCnt;
  reg                      pushLow;
  reg                      kickLast;
  reg                      wdExpire;
  reg                      selfDrive;

  wire levelsOk;
  wire kickEdge;
  wire pinLowExt;

  // comparator flags and pins pass two flops first; flags reset low
  ssrw_sync2 #(.RESET_VAL(1'b0)) uSupply (
    .sys_clk (sys_clk),
    .srst    (srst),
    .asyncIn (supplyOk),
    .syncOut (supplySync)
  ); // see R16
  ssrw_sync2 #(.RESET_VAL(1'b0)) uSense (
    .sys_clk (sys_clk),
    .srst    (srst),
    .asyncIn (senseOk),
    .syncOut (senseSync)
  );
  ssrw_sync2 #(.RESET_VAL(1'b0)) uKick (
    .sys_clk (sys_clk),
    .srst    (srst),
    .asyncIn (kickInput),
    .syncOut (kickSync)
  );
  ssrw_sync2 #(.RESET_VAL(1'b1)) uPin (
    .sys_clk (sys_clk),
    .srst    (srst),
    .asyncIn (resetPinIn),
    .syncOut (pinSync)
  );

  // both monitors must be good on the dual variant
  assign levelsOk = supplySync &
                    ((DUAL_MON != 0) ? senseSync : 1'b1); // see R01 see R11

  // free-running millisecond tick for every long timeout
  always @(posedge sys_clk) begin
    if (srst) begin
      tickCnt <= `SSRW_TICK_ZERO;
      tick    <= 1'b0;
    end else if (tickCnt == TICK_CYC[`SSRW_TICK_W-1:0] - `SSRW_TICK_ONE) begin
      tickCnt <= `SSRW_TICK_ZERO;
      tick    <= 1'b1; // see R16
    end else begin
      tickCnt <= tickCnt + `SSRW_TICK_ONE;
      tick    <= 1'b0;
    end
  end

  // the pin is low from outside only when we are not pulling it ourselves;
  // the pin lags our drive by the synchroniser, so selfDrive is delayed too
  assign pinLowExt = ~pinSync & ~selfDrive; // see R12

  // debounce: the pin must stay low for the full push time to count
  always @(posedge sys_clk) begin
    if (srst) begin
      pushCnt <= `SSRW_PUSH_ZERO;
      pushLow <= 1'b0;
    end else if (!pinLowExt) begin
      pushCnt <= `SSRW_PUSH_ZERO;
      pushLow <= 1'b0; // see R05
    end else if (pushCnt >= `SSRW_PUSH_CYC - `SSRW_PUSH_ONE) begin
      pushLow <= 1'b1; // see R06
    end else begin
      pushCnt <= pushCnt + `SSRW_PUSH_ONE;
    end
  end

  // any edge of the synchronised kick counts
  assign kickEdge = kickSync ^ kickLast; // see R14

  always @(posedge sys_clk) begin
    if (srst) begin
      kickLast <= 1'b0;
    end else begin
      kickLast <= kickSync;
    end
  end

  // startup window after power-on; no watchdog trips until it ends
  always @(posedge sys_clk) begin
    if (srst) begin
      startCnt  <= `SSRW_MS_ZERO;
      startDone <= 1'b0;
    end else if (!startDone && tick) begin
      if (startCnt == START_MS[`SSRW_MS_W-1:0] - `SSRW_MS_ONE) begin
        startDone <= 1'b1; // see R10 see R15
      end else begin
        startCnt <= startCnt + `SSRW_MS_ONE;
      end
    end
  end

  // normal watchdog: cleared by any reset state or any kick edge
  always @(posedge sys_clk) begin
    if (srst) begin
      kickCnt  <= `SSRW_MS_ZERO;
      wdExpire <= 1'b0;
    end else if (state == ST_HOLD || kickEdge || !startDone) begin
      kickCnt  <= `SSRW_MS_ZERO; // see R09
      wdExpire <= 1'b0;
    end else if (tick) begin
      if (kickCnt == KICK_MS[`SSRW_MS_W-1:0] - `SSRW_MS_ONE) begin
        kickCnt  <= `SSRW_MS_ZERO;
        wdExpire <= (HAS_WATCHDOG != 0); // see R08 see R15
      end else begin
        kickCnt  <= kickCnt + `SSRW_MS_ONE;
        wdExpire <= 1'b0;
      end
    end else begin
      wdExpire <= 1'b0;
    end
  end

  // sequencer: any cause returns to hold, hold ends after the full time
  always @* begin
    next_state = state;
    case (state)
      ST_HOLD: begin
        if (levelsOk && !pushLow && tick &&
            holdCnt == HOLD_MS[`SSRW_MS_W-1:0] - `SSRW_MS_ONE) begin
          next_state = ST_RUN; // see R02 see R04 see R07
        end
      end
      ST_RUN: begin
        if (!levelsOk || pushLow || wdExpire) begin
          next_state = ST_HOLD; // see R01 see R06 see R08
        end
      end
      default: begin
        next_state = ST_HOLD;
      end
    endcase
  end

  // hold count restarts whenever any cause is still present
  always @(posedge sys_clk) begin
    if (srst) begin
      state   <= ST_HOLD; // see R03
      holdCnt <= `SSRW_MS_ZERO;
    end else begin
      state <= next_state;
      if (state == ST_RUN || !levelsOk || pushLow) begin
        holdCnt <= `SSRW_MS_ZERO; // see R02 see R07
      end else if (tick) begin
        holdCnt <= holdCnt + `SSRW_MS_ONE;
      end
    end
  end

  // outputs from one state, registered; the pin drives only a low
  always @(posedge sys_clk) begin
    if (srst) begin
      resetHigh   <= 1'b1; // see R03
      resetOutLow <= 1'b0;
      resetPinOut <= 1'b0;
      resetPinOe  <= 1'b1;
      selfDrive   <= 1'b1;
    end else begin
      resetHigh   <= (next_state == ST_HOLD); // see R17
      resetOutLow <= (next_state != ST_HOLD);
      resetPinOut <= 1'b0;
      resetPinOe  <= (next_state == ST_HOLD); // see R12
      // stays set one cycle after resetPinOe falls to cover synchroniser lag
      selfDrive   <= (next_state == ST_HOLD) | resetPinOe;
    end
  end

endmodule // ssrw_supervisor

// >>> tb/ssrw_props.sv
/* ssrw_props.sv: port assertions for the reset supervisor.
   Assumes one clock and srst as power-up; bound to ssrw_supervisor. */
`timescale 1ns/1ps
module ssrw_props #(
  parameter HOLD_MS  = 200,
  parameter KICK_MS  = 1600,
  parameter START_MS = 51000,
  parameter TICK_CYC = 40000
) (
  // clock and reset
  input wire sys_clk,
  input wire srst,
  // observed ports
  input wire supplyOk,
  input wire senseOk,
  input wire kickInput,
  input wire resetPinIn,
  input wire resetPinOut,
  input wire resetPinOe,
  input wire resetHigh,
  input wire resetOutLow
);
  localparam int HG = (HOLD_MS - 1) * TICK_CYC;
  localparam int WD = KICK_MS * TICK_CYC + 12;
  localparam int SW = (START_MS + KICK_MS) * TICK_CYC + 12;
  int goodCnt, lowCnt, idleCnt, upCnt;
  logic kickQ;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  // run lengths; plain ints are wide enough for any sim run
  always @(posedge sys_clk) begin
    kickQ   <= kickInput;
    goodCnt <= (supplyOk && senseOk) ? goodCnt + 1 : 0;
    lowCnt  <= resetPinIn ? 0 : lowCnt + 1;
    upCnt   <= srst ? 0 : upCnt + 1;
    idleCnt <= (srst || resetHigh || kickInput != kickQ) ? 0 : idleCnt + 1;
  end
  sequence s_supLow; !supplyOk [*5]; endsequence
  sequence s_rise; $rose(resetHigh) && goodCnt > 8 && $past(resetPinIn);
  endsequence
  property p_comp; resetOutLow != resetHigh; endproperty
  property p_oe; resetPinOe == resetHigh && !resetPinOut; endproperty
  property p_rst; $fell(srst) |-> resetHigh; endproperty
  property p_uv; s_supLow |-> resetHigh; endproperty
  property p_sense; !senseOk [*5] |-> resetHigh; endproperty
  property p_rel; $fell(resetHigh) |-> goodCnt >= HG; endproperty
  property p_push; lowCnt == 48 |-> resetHigh; endproperty
  property p_wd; idleCnt >= WD && upCnt >= SW |-> resetHigh; endproperty
  property p_start; s_rise |-> upCnt >= START_MS * TICK_CYC; endproperty
  property p_clr; s_rise |-> idleCnt >= (KICK_MS - 1) * TICK_CYC;
  endproperty
  a_comp: assert property (p_comp) else $error("outputs not complements");
  a_oe: assert property (p_oe) else $error("pin drive not reset");
  a_rst: assert property (p_rst) else $error("no reset at power-up");
  a_uv: assert property (p_uv) else $error("supply low, no reset");
  a_sense: assert property (p_sense) else $error("sense low, no reset");
  a_rel: assert property (p_rel) else $error("release too early");
  a_push: assert property (p_push) else $error("push ignored");
  a_wd: assert property (p_wd) else $error("watchdog did not trip");
  a_start: assert property (p_start) else $error("trip in startup");
  a_clr: assert property (p_clr) else $error("watchdog early");
endmodule // ssrw_props

bind ssrw_supervisor ssrw_props #(.HOLD_MS(HOLD_MS), .KICK_MS(KICK_MS),
  .START_MS(START_MS), .TICK_CYC(TICK_CYC)) u_props (.sys_clk(sys_clk),
  .srst(srst), .supplyOk(supplyOk), .senseOk(senseOk),
  .kickInput(kickInput), .resetPinIn(resetPinIn),
  .resetPinOut(resetPinOut), .resetPinOe(resetPinOe),
  .resetHigh(resetHigh), .resetOutLow(resetOutLow));

// >>> tb/ssrw_host_kick.sv
/* ssrw_host_kick.sv: host model that toggles the kick line.
   Assumes the bench enables it; stopping it lets the watchdog expire. */
`timescale 1ns/1ps
module ssrw_host_kick #(
  parameter GAP = 40
) (
  // clock and enable
  input  wire  sys_clk,
  input  wire  kickEn,
  // kick line
  output logic kickInput
);
  int cnt = 0;
  initial kickInput = 1'b0;
  // toggle well inside the window; both edges are kicks
  always @(posedge sys_clk) begin
    cnt <= (kickEn && cnt < GAP) ? cnt + 1 : 0;
    if (kickEn && cnt == GAP) kickInput <= #2 ~kickInput;
  end
endmodule // ssrw_host_kick

// >>> tb/tb.sv
/* tb.sv: self-checking bench for the reset supervisor.
   Assumes short tick parameters; host model drives the kick line. */
`timescale 1ns/1ps
module tb;
  // one tick per cycle; kick and startup windows keep the design defaults
  localparam int TK = 1, HO = 20, KI = 1600, ST = 51000;
  logic sys_clk = 0, srst = 1, supplyOk = 0, senseOk = 1;
  logic pushLow = 0, kickEn = 0;
  wire  kickInput, resetPinOut, resetPinOe, resetHigh, resetOutLow;
  wire  resetPinIn = !(resetPinOe || pushLow);
  int   bad_count = 0, comparisons = 0, n, len;
  logic [31:0] rs = 32'h0000000A;
  logic expQ[$];
  ssrw_supervisor #(.HOLD_MS(HO),
    .TICK_CYC(TK)) u_dut (.sys_clk(sys_clk), .srst(srst),
    .supplyOk(supplyOk), .senseOk(senseOk), .kickInput(kickInput),
    .resetPinIn(resetPinIn), .resetPinOut(resetPinOut),
    .resetPinOe(resetPinOe), .resetHigh(resetHigh),
    .resetOutLow(resetOutLow));
  ssrw_host_kick u_host (.sys_clk(sys_clk), .kickEn(kickEn),
    .kickInput(kickInput));
  function automatic logic [31:0] rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction
  task automatic check(logic got, logic exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: value mismatch", $time);
    end
  endtask
  task automatic cyc(int k);
    repeat (k) @(posedge sys_clk);
    #2;
  endtask
  // bounded wait for a reset level
  task automatic waitRh(logic v, int mx);
    n = 0;
    while (resetHigh !== v && n < mx) begin
      cyc(1);
      n++;
    end
  endtask
  task automatic results();
    $display("Comparisons %0d, errors %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial forever #12.5 sys_clk = ~sys_clk;
  // every reset edge must have been announced by the driver
  always @(resetHigh) if (!srst) begin
    #1;
    check(resetOutLow, ~resetHigh);
    check(resetHigh, expQ.size() ? expQ.pop_front() : ~resetHigh);
  end
  // main sequence
  initial begin
    cyc(8);
    srst = 0;
    supplyOk = 1;
    check(resetHigh, 1);
    expQ.push_back(0);
    waitRh(0, 200);
    check(n >= (HO-1)*TK && n <= (HO+1)*TK+8, 1);
    cyc(ST*TK - n - 20);
    check(resetHigh, 0);
    expQ.push_back(1);
    waitRh(1, KI*TK+80);
    check(n >= KI*TK && resetHigh, 1);
    kickEn = 1;
    expQ.push_back(0);
    waitRh(0, HO*TK+40);
    cyc(KI*TK*2);
    check(resetHigh, 0);
    for (int i = 0; i < 4; i++) begin
      len = 6 + rnd() % 20;
      expQ.push_back(1);
      if (i % 2) senseOk = 0;
      else supplyOk = 0;
      cyc(len);
      check(resetHigh, 1);
      supplyOk = 1;
      senseOk = 1;
      expQ.push_back(0);
      waitRh(0, HO*TK+40);
      check(n >= (HO-1)*TK && !resetHigh, 1);
    end
    pushLow = 1;
    cyc(10);
    pushLow = 0;
    cyc(8);
    check(resetHigh, 0);
    expQ.push_back(1);
    pushLow = 1;
    // the shared pin hides the button while we drive it, so let go
    // as soon as reset shows; the hold is counted from assertion anyway
    waitRh(1, 80);
    check(n >= 40 && resetHigh, 1);
    pushLow = 0;
    expQ.push_back(0);
    waitRh(0, HO*TK+40);
    check(n >= (HO-1)*TK && !resetHigh, 1);
    results();
  end
  // hang guard
  initial begin
    // startup plus three watchdog windows is about 56k cycles; allow 80k
    #2000000;
    bad_count++;
    results();
  end
endmodule // tb
